// *** pkg/gcr_pkg.sv ***
/*
 * constants, field layout, reset values and level-code tables for the
 * gain control and channel enable register bank.
 * assumes an AXI4-Lite master with 32-bit data and 12-bit byte addresses.
 */
package gcr_pkg;
    localparam int         ADDR_W          = 12;
    localparam int         DATA_W          = 32;
    localparam int         N_CH            = 8;
    localparam int         IDX_LSB         = 2;
    localparam int         IDX_MSB         = 9;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FUNC_SEL    = 8'h6c;
    localparam logic [7:0] IDX_ENH_CFG     = 8'h6d;
    localparam logic [7:0] IDX_GAINCTL_CFG = 8'h70;
    localparam logic [7:0] IDX_IN_EN       = 8'h73;
    localparam logic [7:0] IDX_SLOT_EN     = 8'h74;
    localparam logic [7:0] IDX_STATUS      = 8'h78;

    localparam logic [7:0] RST_ENH_CFG     = 8'h7b;
    localparam logic [7:0] RST_GAINCTL_CFG = 8'he7;
    localparam logic [7:0] RST_IN_EN       = 8'hf0;
    localparam logic [7:0] RST_SLOT_EN     = 8'h00;
    localparam logic       RST_FUNC_SEL    = 1'b0;

    // field positions inside a config byte
    localparam int         LVL_HI          = 7;
    localparam int         LVL_LO          = 4;
    localparam int         CEIL_HI         = 3;
    localparam int         CEIL_LO         = 0;
    localparam int         SEL_BIT         = 3;

    // code to dB: base + step * code, codes above last are reserved
    localparam logic [6:0] ENH_THR_BASE    = 7'h0c;
    localparam logic [6:0] ENH_THR_STEP    = 7'h06;
    localparam logic [3:0] ENH_THR_LAST    = 4'h9;
    localparam logic [6:0] ENH_CEIL_BASE   = 7'h02;
    localparam logic [6:0] ENH_CEIL_STEP   = 7'h02;
    localparam logic [3:0] ENH_CEIL_LAST   = 4'hc;
    localparam logic [6:0] GC_TGT_BASE     = 7'h06;
    localparam logic [6:0] GC_TGT_STEP     = 7'h02;
    localparam logic [3:0] GC_TGT_LAST     = 4'hf;
    localparam logic [6:0] GC_CEIL_BASE    = 7'h03;
    localparam logic [6:0] GC_CEIL_STEP    = 7'h03;
    localparam logic [3:0] GC_CEIL_LAST    = 4'hd;

    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic {
        GCR_FUNC_ENHANCER = 1'b0,
        GCR_FUNC_GAINCTL  = 1'b1
    } gcr_func_t;
endpackage

// *** pkg/gcr_regbus_if.sv ***
/*
 * register access strobes between the bus slave and the register bank.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface gcr_regbus_if;
    logic       wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic       wr_ok;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic       rd_ok;

    modport slave (output wr_en, wr_idx, wr_data, rd_idx, input wr_ok, rd_data, rd_ok);
    modport regs  (input wr_en, wr_idx, wr_data, rd_idx, output wr_ok, rd_data, rd_ok);
endinterface

// *** design/gcr_field_decode.sv ***
/*
 * turns a four-bit level code into a dB magnitude on a uniform step.
 * assumes the code is a stable register output; purely combinational.
 */
`timescale 1ns/1ps
module gcr_field_decode #(
    parameter logic [6:0] BASE = 7'h00,
    parameter logic [6:0] STEP = 7'h01,
    parameter logic [3:0] LAST = 4'hf
) (
    input  wire logic [3:0] code,     // field code
    output logic      [6:0] db,       // dB magnitude
    output logic            reserved  // code above last legal one
);
    wire        [3:0]  eff_code;
    wire        [10:0] prod;

    // reserved codes saturate at the last legal step instead of wrapping
    assign reserved = code > LAST;
    assign eff_code = reserved ? LAST : code;
    assign prod     = 11'(STEP) * 11'(eff_code);
    assign db       = BASE + prod[6:0];
endmodule

// *** design/gcr_axil_slave.sv ***
/*
 * AXI4-Lite slave front end: takes address and data in either order,
 * answers one write and one read at a time.
 * assumes the register bank decodes indices combinationally.
 */
`timescale 1ns/1ps
module gcr_axil_slave
    import gcr_pkg::*;
(
    input  wire logic                   mclk,     // system clock
    input  wire logic                   rst,      // async reset, high
    input  wire logic [ADDR_W-1:0]      awaddr,   // write address
    input  wire logic                   awvalid,  // write address valid
    output logic                        awready,  // write address ready
    input  wire logic [DATA_W-1:0]      wdata,    // write data
    input  wire logic [DATA_W/8-1:0]    wstrb,    // write strobes
    input  wire logic                   wvalid,   // write data valid
    output logic                        wready,   // write data ready
    output logic      [1:0]             bresp,    // write response
    output logic                        bvalid,   // write response valid
    input  wire logic                   bready,   // write response ready
    input  wire logic [ADDR_W-1:0]      araddr,   // read address
    input  wire logic                   arvalid,  // read address valid
    output logic                        arready,  // read address ready
    output logic      [DATA_W-1:0]      rdata,    // read data
    output logic      [1:0]             rresp,    // read response
    output logic                        rvalid,   // read data valid
    input  wire logic                   rready,   // read data ready
    gcr_regbus_if.slave                 bus       // register strobes
);
    logic [7:0] aw_idx_r;
    logic       aw_bad_r;
    logic [7:0] w_data_r;
    logic       w_strb_r;

    wire aw_hs  = awvalid & awready;
    wire w_hs   = wvalid & wready;
    wire b_hs   = bvalid & bready;
    wire ar_hs  = arvalid & arready;
    wire r_hs   = rvalid & rready;
    // both halves held and no response outstanding
    wire wr_go  = ~awready & ~wready & ~bvalid;
    wire ar_bad = araddr[ADDR_W-1:IDX_MSB+1] != '0;
    wire wr_ok  = bus.wr_ok & ~aw_bad_r;
    wire rd_ok  = bus.rd_ok & ~ar_bad;

    assign bus.wr_idx  = aw_idx_r;
    assign bus.wr_data = w_data_r;
    assign bus.wr_en   = wr_go & w_strb_r & wr_ok;
    assign bus.rd_idx  = araddr[IDX_MSB:IDX_LSB];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awready  <= 1'b1;
            wready   <= 1'b1;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
            aw_idx_r <= 8'h00;
            aw_bad_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
        end else begin
            if (aw_hs) begin
                awready  <= 1'b0;
                aw_idx_r <= awaddr[IDX_MSB:IDX_LSB];
                aw_bad_r <= awaddr[ADDR_W-1:IDX_MSB+1] != '0;
            end else if (b_hs) begin
                awready <= 1'b1;
            end
            if (w_hs) begin
                wready   <= 1'b0;
                w_data_r <= wdata[7:0];
                w_strb_r <= wstrb[0];
            end else if (b_hs) begin
                wready <= 1'b1;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (b_hs) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rresp   <= RESP_OKAY;
            rdata   <= '0;
        end else if (ar_hs) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata   <= rd_ok ? {24'h000000, bus.rd_data} : '0;
        end else if (r_hs) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule

// *** design/gcr_regs_top.sv ***
/*
 * gain control and channel enable register bank with AXI4-Lite access.
 * holds range enhancer and gain controller settings, the function select,
 * input channel enables and serial output slot drive enables.
 * assumes the datapath reads the registered outputs on the same clock.
 */
`timescale 1ns/1ps

// Overview of operation
// - enhancer threshold in bits 7-4, code 0 is -12 dB, resets to code 7
// - threshold codes 7,8,9 give -54,-60,-66 dB; codes 10-15 reserved
// - enhancer gain ceiling in bits 3-0, 2 dB plus 2 dB per code, reset 11
// - ceiling code 11 is 24 dB, 12 is 26 dB; codes 13-15 reserved
// - controller target in bits 7-4, -6 dB minus 2 dB per code, reset 14
// - target codes 14 and 15 give -34 and -36 dB; none reserved
// - controller ceiling 3 dB per code up to 42 dB; 14-15 reserved; reset 7
// - input enable register, bit 7 is channel 1 down to bit 0 channel 8
// - channels 5-8 digital microphones only; reset enables channels 1-4 only
// - slot enable bit 7 channel 1; zero tri-states slot; all reset to zero
// - controller config at 0x70, input enables 0x73, slot enables 0x74
// - select bit 0 runs enhancer, 1 controller; only selected fields act
module gcr_regs_top
    import gcr_pkg::*;
(
    input  wire logic                   mclk,          // system clock, 10 MHz
    input  wire logic                   rst,           // async reset, high
    input  wire logic [ADDR_W-1:0]      s_awaddr,      // write address
    input  wire logic                   s_awvalid,     // write address valid
    output logic                        s_awready,     // write address ready
    input  wire logic [DATA_W-1:0]      s_wdata,       // write data
    input  wire logic [DATA_W/8-1:0]    s_wstrb,       // write strobes
    input  wire logic                   s_wvalid,      // write data valid
    output logic                        s_wready,      // write data ready
    output logic      [1:0]             s_bresp,       // write response
    output logic                        s_bvalid,      // write response valid
    input  wire logic                   s_bready,      // write response ready
    input  wire logic [ADDR_W-1:0]      s_araddr,      // read address
    input  wire logic                   s_arvalid,     // read address valid
    output logic                        s_arready,     // read address ready
    output logic      [DATA_W-1:0]      s_rdata,       // read data
    output logic      [1:0]             s_rresp,       // read response
    output logic                        s_rvalid,      // read data valid
    input  wire logic                   s_rready,      // read data ready
    output gcr_pkg::gcr_func_t          enhancer_or_gainctl_select, // active function
    output logic      [6:0]             active_level_db,   // dB below full scale
    output logic      [6:0]             active_ceiling_db, // max gain in dB
    output logic                        active_code_reserved, // reserved code set
    output logic      [N_CH-1:0]        input_chan_on,     // index 0 is channel 1
    output logic      [N_CH-1:0]        chan_gain_active,  // function runs on chan
    output logic      [N_CH-1:0]        slot_chan_drive    // slot output enable
);
    import gcr_pkg::*;

    gcr_regbus_if bus ();

    logic [7:0]      enh_cfg_r;
    logic [7:0]      gainctl_cfg_r;
    gcr_func_t       func_sel_r;
    logic [N_CH-1:0] in_on_r;
    logic [N_CH-1:0] slot_on_r;
    logic [N_CH-1:0] in_on_nxt;
    logic [N_CH-1:0] slot_on_nxt;
    logic [N_CH-1:0] in_rd_bits;
    logic [N_CH-1:0] slot_rd_bits;

    wire [6:0] enh_thr_db;
    wire [6:0] enh_ceil_db;
    wire [6:0] gc_tgt_db;
    wire [6:0] gc_ceil_db;
    wire       enh_thr_rsv;
    wire       enh_ceil_rsv;
    wire       gc_tgt_rsv;
    wire       gc_ceil_rsv;

    gcr_axil_slave u_axil (
        .mclk    (mclk),
        .rst     (rst),
        .awaddr  (s_awaddr),
        .awvalid (s_awvalid),
        .awready (s_awready),
        .wdata   (s_wdata),
        .wstrb   (s_wstrb),
        .wvalid  (s_wvalid),
        .wready  (s_wready),
        .bresp   (s_bresp),
        .bvalid  (s_bvalid),
        .bready  (s_bready),
        .araddr  (s_araddr),
        .arvalid (s_arvalid),
        .arready (s_arready),
        .rdata   (s_rdata),
        .rresp   (s_rresp),
        .rvalid  (s_rvalid),
        .rready  (s_rready),
        .bus     (bus.slave)
    );

    wire hit_w_sel  = bus.wr_idx == IDX_FUNC_SEL;
    wire hit_w_enh  = bus.wr_idx == IDX_ENH_CFG;
    wire hit_w_gc   = bus.wr_idx == IDX_GAINCTL_CFG;
    wire hit_w_in   = bus.wr_idx == IDX_IN_EN;
    wire hit_w_slot = bus.wr_idx == IDX_SLOT_EN;
    wire hit_r_sel  = bus.rd_idx == IDX_FUNC_SEL;
    wire hit_r_enh  = bus.rd_idx == IDX_ENH_CFG;
    wire hit_r_gc   = bus.rd_idx == IDX_GAINCTL_CFG;
    wire hit_r_in   = bus.rd_idx == IDX_IN_EN;
    wire hit_r_slot = bus.rd_idx == IDX_SLOT_EN;
    wire hit_r_stat = bus.rd_idx == IDX_STATUS;

    // status is read-only, so a write to it is refused
    assign bus.wr_ok = hit_w_sel | hit_w_enh | hit_w_gc | hit_w_in | hit_w_slot;
    assign bus.rd_ok = hit_r_sel | hit_r_enh | hit_r_gc | hit_r_in | hit_r_slot
                     | hit_r_stat;

    // channel order reversed against the register bits
    genvar ch;
    generate
        for (ch = 0; ch < N_CH; ch++) begin : g_chan
            assign in_on_nxt[ch]   = (bus.wr_en & hit_w_in) ? bus.wr_data[N_CH-1-ch]
                                                            : in_on_r[ch];
            assign slot_on_nxt[ch] = (bus.wr_en & hit_w_slot) ? bus.wr_data[N_CH-1-ch]
                                                              : slot_on_r[ch];
            assign in_rd_bits[N_CH-1-ch]   = in_on_r[ch];
            assign slot_rd_bits[N_CH-1-ch] = slot_on_r[ch];
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    in_on_r[ch]   <= RST_IN_EN[N_CH-1-ch];
                    slot_on_r[ch] <= RST_SLOT_EN[N_CH-1-ch];
                end else begin
                    in_on_r[ch]   <= in_on_nxt[ch];
                    slot_on_r[ch] <= slot_on_nxt[ch];
                end
            end
        end
    endgenerate

    // config bytes with their reset codes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enh_cfg_r     <= RST_ENH_CFG;
            gainctl_cfg_r <= RST_GAINCTL_CFG;
            func_sel_r    <= gcr_func_t'(RST_FUNC_SEL);
        end else if (bus.wr_en) begin
            if (hit_w_enh) begin
                enh_cfg_r <= bus.wr_data;
            end
            if (hit_w_gc) begin
                gainctl_cfg_r <= bus.wr_data;
            end
            if (hit_w_sel) begin
                func_sel_r <= gcr_func_t'(bus.wr_data[SEL_BIT]);
            end
        end
    end

    gcr_field_decode #(
        .BASE (ENH_THR_BASE),
        .STEP (ENH_THR_STEP),
        .LAST (ENH_THR_LAST)
    ) u_enh_thr (
        .code     (enh_cfg_r[LVL_HI:LVL_LO]),
        .db       (enh_thr_db),
        .reserved (enh_thr_rsv)
    );

    gcr_field_decode #(
        .BASE (ENH_CEIL_BASE),
        .STEP (ENH_CEIL_STEP),
        .LAST (ENH_CEIL_LAST)
    ) u_enh_ceil (
        .code     (enh_cfg_r[CEIL_HI:CEIL_LO]),
        .db       (enh_ceil_db),
        .reserved (enh_ceil_rsv)
    );

    gcr_field_decode #(
        .BASE (GC_TGT_BASE),
        .STEP (GC_TGT_STEP),
        .LAST (GC_TGT_LAST)
    ) u_gc_tgt (
        .code     (gainctl_cfg_r[LVL_HI:LVL_LO]),
        .db       (gc_tgt_db),
        .reserved (gc_tgt_rsv)
    );

    gcr_field_decode #(
        .BASE (GC_CEIL_BASE),
        .STEP (GC_CEIL_STEP),
        .LAST (GC_CEIL_LAST)
    ) u_gc_ceil (
        .code     (gainctl_cfg_r[CEIL_HI:CEIL_LO]),
        .db       (gc_ceil_db),
        .reserved (gc_ceil_rsv)
    );

    // only the selected function's fields reach the datapath
    wire       sel_gc     = func_sel_r == GCR_FUNC_GAINCTL;
    wire [6:0] level_nxt  = sel_gc ? gc_tgt_db : enh_thr_db;
    wire [6:0] ceil_nxt   = sel_gc ? gc_ceil_db : enh_ceil_db;
    wire       rsv_nxt    = sel_gc ? (gc_tgt_rsv | gc_ceil_rsv)
                                   : (enh_thr_rsv | enh_ceil_rsv);
    wire [7:0] status_rd  = {3'h0, gc_ceil_rsv, enh_ceil_rsv, enh_thr_rsv,
                             rsv_nxt, sel_gc};

    // reads of unmapped indices give zero, the slave flags them
    assign bus.rd_data = hit_r_sel  ? {4'h0, sel_gc, 3'h0} :
                         hit_r_enh  ? enh_cfg_r :
                         hit_r_gc   ? gainctl_cfg_r :
                         hit_r_in   ? in_rd_bits :
                         hit_r_slot ? slot_rd_bits :
                         hit_r_stat ? status_rd : 8'h00;

    // outputs registered; decoded values settle one cycle after a write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enhancer_or_gainctl_select <= GCR_FUNC_ENHANCER;
            active_level_db            <= 7'h00;
            active_ceiling_db          <= 7'h00;
            active_code_reserved       <= 1'b0;
            input_chan_on              <= '0;
            chan_gain_active           <= '0;
            slot_chan_drive            <= '0;
        end else begin
            enhancer_or_gainctl_select <= func_sel_r;
            active_level_db            <= level_nxt;
            active_ceiling_db          <= ceil_nxt;
            active_code_reserved       <= rsv_nxt;
            input_chan_on              <= in_on_r;
            // function acts only on enabled channels
            chan_gain_active           <= in_on_r;
            slot_chan_drive            <= slot_on_r;
        end
    end
endmodule

// *** dv/gcr_regs_checker.sv ***
/*
 * concurrent checks on the bus handshake and decoded outputs of the bank.
 * assumes it is bound onto gcr_regs_top and sees only its ports.
 */
`timescale 1ns/1ps
module gcr_regs_checker
    import gcr_pkg::*;
(
    input wire logic                   mclk,                       // clock
    input wire logic                   rst,                        // async reset
    input wire logic                   s_awvalid,                  // aw valid
    input wire logic                   s_awready,                  // aw ready
    input wire logic                   s_wvalid,                   // w valid
    input wire logic                   s_wready,                   // w ready
    input wire logic                   s_bvalid,                   // b valid
    input wire logic                   s_arvalid,                  // ar valid
    input wire logic                   s_arready,                  // ar ready
    input wire logic                   s_rvalid,                   // r valid
    input wire logic                   s_rready,                   // r ready
    input wire logic      [1:0]        s_bresp,                    // b response
    input wire logic      [DATA_W-1:0] s_rdata,                    // read data
    input wire gcr_pkg::gcr_func_t     enhancer_or_gainctl_select, // function
    input wire logic      [6:0]        active_level_db,            // level
    input wire logic      [6:0]        active_ceiling_db,          // ceiling
    input wire logic                   active_code_reserved,       // reserved
    input wire logic      [N_CH-1:0]   input_chan_on,              // channels
    input wire logic      [N_CH-1:0]   chan_gain_active,           // gain on
    input wire logic      [N_CH-1:0]   slot_chan_drive             // slot drive
);
    logic [1:0] live_r;
    logic       live;
    logic       enh;

    // decoded outputs settle a couple of edges after reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            live_r <= 2'h0;
        end else if (live_r != 2'h3) begin
            live_r <= live_r + 2'h1;
        end
    end
    assign live = (live_r == 2'h3);
    assign enh  = (enhancer_or_gainctl_select == GCR_FUNC_ENHANCER);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid && s_rdata[31:8] == 24'h0)
        else $error("read answer wrong");
    busy_block_a: assert property (s_bvalid |-> !s_awready && !s_wready && !s_arready == s_rvalid)
        else $error("ready during response");
    gain_chan_a: assert property (live |-> chan_gain_active == input_chan_on)
        else $error("gain channels differ");
    enh_range_a: assert property (live && enh |-> active_level_db >= 12 &&
        active_level_db <= 66 && active_level_db % 6 == 0 && active_ceiling_db >= 2 &&
        active_ceiling_db <= 26 && !active_ceiling_db[0]) else $error("enhancer decode");
    ctl_range_a: assert property (live && !enh |-> active_level_db >= 6 &&
        active_level_db <= 36 && !active_level_db[0] && active_ceiling_db >= 3 &&
        active_ceiling_db <= 42 && active_ceiling_db % 3 == 0) else $error("control decode");
    rsv_sat_a: assert property (live && active_code_reserved |-> (enh ?
        (active_level_db == 66 || active_ceiling_db == 26) : active_ceiling_db == 42))
        else $error("reserved not saturated");
    chg_cause_a: assert property (live && ($changed(input_chan_on) ||
        $changed(slot_chan_drive) || $changed(enhancer_or_gainctl_select)) |-> $past(s_bvalid))
        else $error("output changed without write");
    rst_values_a: assert property ($fell(rst) |=> input_chan_on == 8'h0f &&
        slot_chan_drive == 8'h00 && active_level_db == 7'h36 && active_ceiling_db == 7'h18)
        else $error("reset values wrong");

    cover property (s_bvalid && s_bresp == RESP_SLVERR);
    cover property (s_rvalid && s_rready);
    cover property (live && !enh && active_code_reserved);
endmodule

bind gcr_regs_top gcr_regs_checker i_chk (.mclk, .rst, .s_awvalid, .s_awready, .s_wvalid,
    .s_wready, .s_bvalid, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_bresp, .s_rdata,
    .enhancer_or_gainctl_select, .active_level_db, .active_ceiling_db, .active_code_reserved,
    .input_chan_on, .chan_gain_active, .slot_chan_drive);

// *** dv/gcr_regs_top_bench.sv ***
/*
 * self-checking bench: table of register accesses, then reset and decode cases.
 * assumes the bank answers over AXI4-Lite; bready and rready stay high.
 */
`timescale 1ns/1ps
module gcr_regs_top_bench;
    import gcr_pkg::*;
    typedef struct {logic [11:0] a; logic [7:0] d; logic [31:0] q; logic [1:0] r;} gcr_row_t;
    logic [ADDR_W-1:0] s_awaddr, s_araddr;
    logic [DATA_W-1:0] s_wdata, s_rdata, rd_d;
    logic [3:0]        s_wstrb;
    logic [1:0]        s_bresp, s_rresp, rsp;
    logic              mclk, rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
    logic              s_bready, s_arvalid, s_arready, s_rvalid, s_rready, rsv;
    gcr_func_t         sel;
    logic [6:0]        lvl, ceil;
    logic [7:0]        chan_on, gain_on, slot_on;
    int                error_cnt, check_count;
    // reserved codes read back as written; select keeps bit 3 only
    gcr_row_t rows[7] = '{'{12'h1c0, 8'h5a, 32'h5a, RESP_OKAY}, '{12'h1cc, 8'ha5, 32'ha5, RESP_OKAY},
        '{12'h1d0, 8'h3c, 32'h3c, RESP_OKAY}, '{12'h1b4, 8'hfd, 32'hfd, RESP_OKAY},
        '{12'h1b0, 8'hff, 32'h08, RESP_OKAY}, '{12'h1c4, 8'h11, 32'h0, RESP_SLVERR},
        '{12'h5c0, 8'h22, 32'h0, RESP_SLVERR}};
    logic [11:0] ra[4] = '{12'h1b4, 12'h1c0, 12'h1cc, 12'h1d0};
    logic [7:0]  rv[4] = '{8'h7b, 8'he7, 8'hf0, 8'h00};

    gcr_regs_top i_dut (.mclk(mclk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .enhancer_or_gainctl_select(sel), .active_level_db(lvl), .active_ceiling_db(ceil),
        .active_code_reserved(rsv), .input_chan_on(chan_on), .chan_gain_active(gain_on),
        .slot_chan_drive(slot_on));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge mclk);
        s_awaddr <= a;
        s_wdata <= {24'h0, d};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            if (s_awvalid && s_awready) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!s_bvalid);
        r = s_bresp;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do @(posedge mclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
    endtask

    // write, then look at the decoded outputs once they have landed
    task automatic setc(input logic [11:0] a, input logic [7:0] d);
        wr(a, d, rsp);
        chk(rsp, RESP_OKAY);
        @(negedge mclk);
    endtask

    task automatic outs(input logic [6:0] lv, input logic [6:0] cl, input logic rs);
        chk(lvl, lv);
        chk(ceil, cl);
        chk(rsv, rs);
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge mclk);
        error_cnt++;
        finish_test;
    end

    initial begin
        {s_awaddr, s_araddr, s_wdata} = '0;
        {s_awvalid, s_wvalid, s_arvalid} = 3'h0;
        {s_bready, s_rready, rst} = 3'h7;
        s_wstrb = 4'hf;
        error_cnt = 0;
        check_count = 0;
        do_reset;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rsp);
            chk(rsp, rows[i].r);
            rd(rows[i].a, rd_d, rsp);
            chk(rd_d, rows[i].q);
            chk(rsp, rows[i].r);
        end
        rd(12'h1c0, rd_d, rsp);
        chk(rd_d, 32'h5a);
        $display("test table done");
        do_reset;
        foreach (ra[i]) begin
            rd(ra[i], rd_d, rsp);
            chk(rd_d, {24'h0, rv[i]});
        end
        chk(sel, GCR_FUNC_ENHANCER);
        outs(7'h36, 7'h18, 1'b0);
        chk(chan_on, 8'h0f);
        chk(gain_on, 8'h0f);
        chk(slot_on, 8'h00);
        $display("test reset done");
        setc(12'h1b4, 8'h35);
        outs(7'h1e, 7'h0c, 1'b0);
        setc(12'h1b4, 8'h0b);
        outs(7'h0c, 7'h18, 1'b0);
        setc(12'h1b4, 8'h9c);
        outs(7'h42, 7'h1a, 1'b0);
        setc(12'h1b4, 8'had);
        outs(7'h42, 7'h1a, 1'b1);
        rd(12'h1e0, rd_d, rsp);
        chk(rd_d, 32'h0e);
        wr(12'h1e0, 8'h00, rsp);
        chk(rsp, RESP_SLVERR);
        $display("test enhancer done");
        setc(12'h1c0, 8'h0d);
        setc(12'h1b0, 8'h08);
        chk(sel, GCR_FUNC_GAINCTL);
        outs(7'h06, 7'h2a, 1'b0);
        setc(12'h1c0, 8'hfe);
        outs(7'h24, 7'h2a, 1'b1);
        setc(12'h1c0, 8'h54);
        outs(7'h10, 7'h0f, 1'b0);
        setc(12'h1b4, 8'h00);
        outs(7'h10, 7'h0f, 1'b0);
        setc(12'h1b0, 8'h00);
        outs(7'h0c, 7'h02, 1'b0);
        $display("test controller done");
        setc(12'h1cc, 8'h80);
        chk(chan_on, 8'h01);
        chk(gain_on, 8'h01);
        setc(12'h1cc, 8'h0e);
        chk(chan_on, 8'h70);
        setc(12'h1d0, 8'hc1);
        chk(slot_on, 8'h83);
        setc(12'h1d0, 8'h00);
        chk(slot_on, 8'h00);
        @(posedge mclk);
        s_wstrb <= 4'he;
        setc(12'h1d0, 8'hff);
        chk(slot_on, 8'h00);
        $display("test channels done");
        finish_test;
    end
endmodule
